// >>> common/irq_pkg.sv
package irq_pkg;
   // ------------------------------------------------------------
   // Register offsets
   // ------------------------------------------------------------
   localparam logic [3:0] ADDR_INT_CTRL0 = 4'h0;
   localparam logic [3:0] ADDR_INT_CTRL1 = 4'h1;
   localparam logic [3:0] ADDR_INT_CTRL2 = 4'h2;
   localparam logic [3:0] ADDR_GROUP0 = 4'h3;
   localparam logic [3:0] ADDR_PSC0 = 4'h7;
   localparam logic [3:0] ADDR_TIMEBASE0_CONTROL = 4'h9;
   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int GLOBAL_BIT = 0;
   localparam int OWN_EN_LSB = 1;
   localparam int OWN_FLAG_LSB = 4;
   localparam int GROUP_EN_LSB = 0;
   localparam int GROUP_FLAG_LSB = 4;
   localparam int TB_EN_LSB = 0;
   localparam int TB_FLAG_LSB = 4;
   localparam int SUB_EN_LSB = 0;
   localparam int SUB_FLAG_LSB = 4;
   localparam int TB_RUN_BIT = 7;
   localparam int PERIOD_LSB = 0;
   localparam int SRC_LSB = 0;
   // ------------------------------------------------------------
   // Values and counts
   // ------------------------------------------------------------
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [1:0] SRC_CORE = 2'h0;
   localparam logic [1:0] SRC_DIV4 = 2'h1;
   localparam logic [1:0] DIV4_LAST = 2'h3;
   localparam logic [14:0] TB_FULL_MASK = 15'h7fff;
   localparam logic [2:0] PERIOD_MAX = 3'h7;
   // ------------------------------------------------------------
   // Vector numbers, lowest number has highest priority
   // ------------------------------------------------------------
   localparam logic [3:0] VEC_TOUCH = 4'h0;
   localparam logic [3:0] VEC_GROUP0 = 4'h3;
   localparam logic [3:0] VEC_TB0 = 4'h7;
   localparam int NUM_VECTORS = 9;
endpackage : irq_pkg

// >>> verilog/irq_ctrl.sv
// Overview of operation
// RQ1: Touch slot counter overflow sets the touch request flag.
// RQ2: Taking touch interrupt clears its flag and global enable; needs both enables.
// RQ3: Any of six UART conditions raises the UART request.
// RQ4: Taking UART interrupt clears its flag and global enable; needs both enables.
// RQ5: Conversion finished sets the converter request flag.
// RQ6: Taking converter interrupt clears its flag and global enable.
// RQ7: Four group interrupts built from timer, low voltage, EEPROM, serial sources.
// RQ8: A group flag sets whenever one of its sources sets its flag.
// RQ9: Servicing a group clears only group flag and global enable.
// RQ10: Vector only when enabled and return stack not full.
// RQ11: Each time base sets its flag on timer overflow.
// RQ12: Taking time base interrupt clears its flag and global enable.
// RQ13: Prescaler source 00 core clock, 01 core clock/4, 1x subclock.
// RQ14: Time base runs only while control bit 7 is one.
// RQ15: Period field gives time-out of 2^(8+field) prescaler periods.
// RQ16: Serial flag sets on byte done, address match or bus time-out.
// RQ17: Software clears the serial flag itself.
// RQ18: Low supply report sets the low voltage flag.
// RQ19: Software clears the low voltage flag itself.
// RQ20: End of EEPROM write sets the EEPROM write flag.
// RQ21: Software clears the EEPROM write flag itself.
// RQ22: Grouped source vectors only with global, own and group enables set.
// RQ23: Any flag rising wakes the device, enabled or not.
// RQ24: Return from interrupt sets global enable; plain return does not.
// RQ25: Simultaneous requests vector by fixed priority, others stay pending.
`timescale 1ns/100ps
module irq_ctrl
   import irq_pkg::*;
(
   input wire logic CLK, // Core clock
   input wire logic RSTN, // Asynchronous reset
   input wire logic [3:0] ADDR, // Register address
   input wire logic [7:0] WDATA, // Write data
   input wire logic WR, // Write strobe
   input wire logic RD, // Read strobe
   output logic [7:0] RDATA, // Read data
   input wire logic TOUCH_OVERFLOW, // Touch slot counter overflow
   input wire logic [5:0] UART_EVENT, // UART conditions
   input wire logic ADC_DONE, // Conversion finished
   input wire logic [4:0] TIMER_EVENT, // Timer compare matches
   input wire logic [2:0] SERIAL_EVENT, // Serial module events
   input wire logic LOW_VOLTAGE, // Low supply report
   input wire logic EEPROM_DONE, // EEPROM write cycle end
   input wire logic SUB_CLOCK, // Low-speed subclock level
   input wire logic STACK_FULL, // Return stack full
   input wire logic RETURN_FROM_INTERRUPT, // Return-from-interrupt executed
   output logic VECTOR_TAKE, // Interrupt call pulse
   output logic [3:0] VECTOR_INDEX, // Vector of the call
   output logic WAKEUP // Wake-up pulse
);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      logic global_en;
      logic [2:0] own_en;
      logic [2:0] own_flag;
      logic [3:0] group_en;
      logic [3:0] group_flag;
      logic [1:0] tb_en;
      logic [1:0] tb_flag;
      logic [7:0] sub_en;
      logic [7:0] sub_flag;
      logic [1:0][1:0] psc_src;
      logic [1:0] tb_run;
      logic [1:0][2:0] tb_period;
      logic [1:0] div4;
      logic sub_clk_q;
      logic [1:0][14:0] tb_count;
      logic [7:0] rdata;
      logic take;
      logic [3:0] vector;
      logic wake;
   } state_type;

   state_type s;
   state_type next_s;

   logic sub_edge;
   logic [1:0] tick;
   logic [1:0] tb_ovf;
   logic [14:0] mask;
   logic [NUM_VECTORS-1:0] req;
   logic found;
   logic [3:0] sel;
   logic [7:0] sub_set;
   logic [7:0] rd_value;
   logic [16:0] old_flags;
   logic [16:0] new_flags;

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      next_s = s;
      next_s.take = 1'b0;
      next_s.wake = 1'b0;
      next_s.rdata = RESET_BYTE;
      next_s.div4 = s.div4 + 2'h1;
      next_s.sub_clk_q = SUB_CLOCK;
      sub_edge = SUB_CLOCK & ~s.sub_clk_q;
      tick = 2'h0;
      tb_ovf = 2'h0;
      mask = TB_FULL_MASK;
      req = '0;
      found = 1'b0;
      sel = VEC_TOUCH;
      rd_value = RESET_BYTE;

      // Register writes
      if (WR) begin
         if (ADDR == ADDR_INT_CTRL0) begin
            next_s.global_en = WDATA[GLOBAL_BIT];
            next_s.own_en = WDATA[OWN_EN_LSB +: 3];
            next_s.own_flag = WDATA[OWN_FLAG_LSB +: 3];
         end else if (ADDR == ADDR_INT_CTRL1) begin
            next_s.group_en = WDATA[GROUP_EN_LSB +: 4];
            next_s.group_flag = WDATA[GROUP_FLAG_LSB +: 4];
         end else if (ADDR == ADDR_INT_CTRL2) begin
            next_s.tb_en = WDATA[TB_EN_LSB +: 2];
            next_s.tb_flag = WDATA[TB_FLAG_LSB +: 2];
         end
         for (int g = 0; g < 4; g++) begin
            if (ADDR == ADDR_GROUP0 + 4'(g)) begin
               next_s.sub_en[2*g +: 2] = WDATA[SUB_EN_LSB +: 2];
               next_s.sub_flag[2*g +: 2] = WDATA[SUB_FLAG_LSB +: 2]; // RQ17 RQ19 RQ21
            end
         end
         for (int t = 0; t < 2; t++) begin
            if (ADDR == ADDR_PSC0 + 4'(t)) begin
               next_s.psc_src[t] = WDATA[SRC_LSB +: 2];
            end
            if (ADDR == ADDR_TIMEBASE0_CONTROL + 4'(t)) begin
               next_s.tb_run[t] = WDATA[TB_RUN_BIT];
               next_s.tb_period[t] = WDATA[PERIOD_LSB +: 3];
            end
         end
      end

      // Return from interrupt re-enables; a plain return has no port
      if (RETURN_FROM_INTERRUPT) begin
         next_s.global_en = 1'b1; // RQ24
      end

      // ---------------------------------------------------------
      // Prescalers and time bases
      // ---------------------------------------------------------
      for (int t = 0; t < 2; t++) begin
         if (s.psc_src[t] == SRC_CORE) begin
            tick[t] = 1'b1; // RQ13
         end else if (s.psc_src[t] == SRC_DIV4) begin
            tick[t] = (s.div4 == DIV4_LAST); // RQ13
         end else begin
            tick[t] = sub_edge; // RQ13
         end
         mask = TB_FULL_MASK >> (PERIOD_MAX - s.tb_period[t]); // RQ15
         if (!s.tb_run[t]) begin
            next_s.tb_count[t] = 15'h0000; // RQ14
         end else if (tick[t]) begin
            if ((s.tb_count[t] & mask) == mask) begin
               next_s.tb_count[t] = 15'h0000;
               tb_ovf[t] = 1'b1; // RQ11 RQ15
            end else begin
               next_s.tb_count[t] = s.tb_count[t] + 15'h0001;
            end
         end
      end

      // ---------------------------------------------------------
      // Requests and priority
      // ---------------------------------------------------------
      for (int i = 0; i < 3; i++) begin
         req[i] = s.own_flag[i] & s.own_en[i]; // RQ2 RQ4 RQ6
      end
      for (int g = 0; g < 4; g++) begin
         req[3+g] = s.group_flag[g] & s.group_en[g]
                  & |(s.sub_flag[2*g +: 2] & s.sub_en[2*g +: 2]); // RQ22
      end
      for (int t = 0; t < 2; t++) begin
         req[7+t] = s.tb_flag[t] & s.tb_en[t]; // RQ12
      end
      for (int i = NUM_VECTORS - 1; i >= 0; i--) begin
         if (req[i]) begin
            found = 1'b1;
            sel = 4'(i); // RQ25
         end
      end

      // Call: only the chosen flag and the global enable clear
      if (s.global_en && !STACK_FULL && found) begin // RQ10
         next_s.take = 1'b1;
         next_s.vector = sel;
         next_s.global_en = 1'b0; // RQ2 RQ4 RQ6 RQ9 RQ12
         for (int i = 0; i < 3; i++) begin
            if (sel == VEC_TOUCH + 4'(i)) begin
               next_s.own_flag[i] = 1'b0; // RQ2 RQ4 RQ6
            end
         end
         for (int g = 0; g < 4; g++) begin
            if (sel == VEC_GROUP0 + 4'(g)) begin
               next_s.group_flag[g] = 1'b0; // RQ9
            end
         end
         for (int t = 0; t < 2; t++) begin
            if (sel == VEC_TB0 + 4'(t)) begin
               next_s.tb_flag[t] = 1'b0; // RQ12
            end
         end
      end

      // ---------------------------------------------------------
      // Events, applied last so a set beats any clear
      // ---------------------------------------------------------
      next_s.own_flag[0] = next_s.own_flag[0] | TOUCH_OVERFLOW; // RQ1
      next_s.own_flag[1] = next_s.own_flag[1] | (|UART_EVENT); // RQ3
      next_s.own_flag[2] = next_s.own_flag[2] | ADC_DONE; // RQ5
      sub_set = {EEPROM_DONE, LOW_VOLTAGE, |SERIAL_EVENT, TIMER_EVENT}; // RQ7 RQ16 RQ18 RQ20
      next_s.sub_flag = next_s.sub_flag | sub_set;
      for (int g = 0; g < 4; g++) begin
         if (|sub_set[2*g +: 2]) begin
            next_s.group_flag[g] = 1'b1; // RQ8
         end
      end
      next_s.tb_flag = next_s.tb_flag | tb_ovf; // RQ11

      // Wake-up on any flag rising, enables ignored
      old_flags = {s.own_flag, s.group_flag, s.tb_flag, s.sub_flag};
      new_flags = {next_s.own_flag, next_s.group_flag, next_s.tb_flag, next_s.sub_flag};
      next_s.wake = |(new_flags & ~old_flags); // RQ23

      // ---------------------------------------------------------
      // Register reads
      // ---------------------------------------------------------
      if (ADDR == ADDR_INT_CTRL0) begin
         rd_value = {1'b0, s.own_flag, s.own_en, s.global_en};
      end else if (ADDR == ADDR_INT_CTRL1) begin
         rd_value = {s.group_flag, s.group_en};
      end else if (ADDR == ADDR_INT_CTRL2) begin
         rd_value = {2'h0, s.tb_flag, 2'h0, s.tb_en};
      end
      for (int g = 0; g < 4; g++) begin
         if (ADDR == ADDR_GROUP0 + 4'(g)) begin
            rd_value = {2'h0, s.sub_flag[2*g +: 2], 2'h0, s.sub_en[2*g +: 2]};
         end
      end
      for (int t = 0; t < 2; t++) begin
         if (ADDR == ADDR_PSC0 + 4'(t)) begin
            rd_value = {6'h00, s.psc_src[t]};
         end
         if (ADDR == ADDR_TIMEBASE0_CONTROL + 4'(t)) begin
            rd_value = {s.tb_run[t], 4'h0, s.tb_period[t]};
         end
      end
      if (RD) begin
         next_s.rdata = rd_value;
      end
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign RDATA = s.rdata;
   assign VECTOR_TAKE = s.take;
   assign VECTOR_INDEX = s.vector;
   assign WAKEUP = s.wake;

endmodule : irq_ctrl

// >>> tb/irq_ctrl_chk.sv
`timescale 1ns/100ps
module irq_ctrl_chk
   import irq_pkg::*;
(
   input wire logic CLK, // Core clock
   input wire logic RSTN, // Reset
   input wire logic [3:0] ADDR, // Address
   input wire logic WR, // Write strobe
   input wire logic RD, // Read strobe
   input wire logic [7:0] RDATA, // Read data
   input wire logic STACK_FULL, // Stack full
   input wire logic RETURN_FROM_INTERRUPT, // Return
   input wire logic VECTOR_TAKE, // Call pulse
   input wire logic [3:0] VECTOR_INDEX, // Vector
   input wire logic WAKEUP // Wake-up
);
   default clocking @(posedge CLK); endclocking
   default disable iff (!RSTN);
   take_pulse_a: assert property (VECTOR_TAKE |=> !VECTOR_TAKE)
      else $error("call pulse too long");
   stack_guard_a: assert property (VECTOR_TAKE |-> !$past(STACK_FULL))
      else $error("call while stack full");
   global_hold_a: assert property (VECTOR_TAKE ##0 (!RETURN_FROM_INTERRUPT && !WR)[*2]
      |=> !VECTOR_TAKE)
      else $error("call without global enable");
   index_hold_a: assert property (!VECTOR_TAKE |-> $stable(VECTOR_INDEX))
      else $error("vector changed without call");
   index_range_a: assert property (VECTOR_TAKE |-> VECTOR_INDEX < NUM_VECTORS)
      else $error("vector out of range");
   psc0_resv_a: assert property (RD && ADDR == ADDR_PSC0 |=> RDATA[7:2] == 6'h00)
      else $error("prescaler 0 spare bits set");
   psc1_resv_a: assert property (RD && ADDR == 4'h8 |=> RDATA[7:2] == 6'h00)
      else $error("prescaler 1 spare bits set");
   tb_resv_a: assert property (RD && ADDR == ADDR_TIMEBASE0_CONTROL |=> RDATA[6:3] == 4'h0)
      else $error("time base spare bits set");
   cover property (VECTOR_TAKE);
   cover property (WAKEUP);
   cover property (STACK_FULL && VECTOR_TAKE == 1'b0);
endmodule : irq_ctrl_chk
bind irq_ctrl irq_ctrl_chk i_chk (.CLK(CLK), .RSTN(RSTN), .ADDR(ADDR), .WR(WR), .RD(RD),
   .RDATA(RDATA), .STACK_FULL(STACK_FULL), .RETURN_FROM_INTERRUPT(RETURN_FROM_INTERRUPT),
   .VECTOR_TAKE(VECTOR_TAKE), .VECTOR_INDEX(VECTOR_INDEX), .WAKEUP(WAKEUP));

// >>> tb/core_model.sv
`timescale 1ns/100ps
module core_model (
   input wire logic clk, // Core clock
   input wire logic rstn, // Reset
   input wire logic vector_take, // Call from controller
   input wire logic auto_return, // Return after each routine
   input wire logic slow, // Long service routine
   output logic return_pulse // Return-from-interrupt
);
   logic [4:0] left;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         left <= 5'h00;
         return_pulse <= 1'b0;
      end else begin
         return_pulse <= (left == 5'h01);
         if (vector_take && auto_return) begin
            left <= slow ? 5'h10 : 5'h02;
         end else if (left != 5'h00) begin
            left <= left - 5'h01;
         end
      end
   end
endmodule : core_model

// >>> tb/irq_ctrl_bench.sv
`timescale 1ns/100ps
module irq_ctrl_bench
   import irq_pkg::*;
;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [7:0] rdata;
   logic [17:0] ev = 18'h0_0000;
   logic [2:0] sub_div = 3'h0;
   logic stack_full = 1'b0;
   logic ret;
   logic take;
   logic [3:0] index;
   logic wake;
   logic auto_ret = 1'b0;
   logic slow = 1'b0;
   logic [7:0] v;
   int n;
   int failures = 0;
   int compares = 0;
   always #50 clk = ~clk;
   // Subclock: one rising edge every 8 core cycles
   always @(posedge clk) begin
      sub_div <= sub_div + 3'h1;
   end
   irq_ctrl i_dut (.CLK(clk), .RSTN(rstn), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
      .RDATA(rdata), .TOUCH_OVERFLOW(ev[0]), .UART_EVENT(ev[6:1]), .ADC_DONE(ev[7]),
      .TIMER_EVENT(ev[14:10]), .SERIAL_EVENT(ev[17:15]), .LOW_VOLTAGE(ev[8]),
      .EEPROM_DONE(ev[9]), .SUB_CLOCK(sub_div[2]), .STACK_FULL(stack_full),
      .RETURN_FROM_INTERRUPT(ret),
      .VECTOR_TAKE(take), .VECTOR_INDEX(index), .WAKEUP(wake));
   core_model i_core (.clk(clk), .rstn(rstn), .vector_take(take), .auto_return(auto_ret),
      .slow(slow), .return_pulse(ret));
   task check(input logic [15:0] seen, input logic [15:0] exp, input string what);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task wrr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wrr
   task rdr(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask : rdr
   task pulse(input logic [17:0] m);
      @(posedge clk);
      ev <= m;
      @(posedge clk);
      ev <= 18'h0_0000;
   endtask : pulse
   task wait_take(input int lim);
      n = 0;
      do begin
         @(posedge clk);
         #1 n++;
      end while (take !== 1'b1 && n < lim);
   endtask : wait_take
   task t_regs;
      rdr(ADDR_TIMEBASE0_CONTROL, v);
      check(v, 8'h00, "tb reset");
      wrr(4'hB, 8'hFF);
      rdr(4'hB, v);
      check(v, 8'h00, "unmapped");
      wrr(ADDR_PSC0, 8'hFF);
      rdr(ADDR_PSC0, v);
      check(v, 8'h03, "psc bits");
      wrr(ADDR_TIMEBASE0_CONTROL, 8'hFF);
      rdr(ADDR_TIMEBASE0_CONTROL, v);
      check(v, 8'h87, "tb bits");
      wrr(ADDR_TIMEBASE0_CONTROL, 8'h00);
      wrr(ADDR_PSC0, 8'h00);
   endtask : t_regs
   task t_adc;
      wrr(ADDR_INT_CTRL0, 8'h09);
      pulse(10'h080);
      #1 check(wake, 1'b1, "wake");
      wait_take(1);
      check(index, 4'h2, "adc vector");
      rdr(ADDR_INT_CTRL0, v);
      check(v, 8'h08, "adc clear");
   endtask : t_adc
   task t_uart;
      for (int k = 0; k < 6; k++) begin
         wrr(ADDR_INT_CTRL0, 8'h04);
         pulse(10'h002 << k);
         rdr(ADDR_INT_CTRL0, v);
         check(v, 8'h24, "uart flag");
      end
   endtask : t_uart
   task t_prio;
      wrr(ADDR_INT_CTRL0, 8'h06);
      pulse(10'h003);
      stack_full <= 1'b1;
      auto_ret <= 1'b1;
      slow <= 1'b1;
      wrr(ADDR_INT_CTRL0, 8'h37);
      wait_take(5);
      check(take, 1'b0, "stack full");
      stack_full <= 1'b0;
      wait_take(10);
      check(index, VEC_TOUCH, "touch first");
      wait_take(40);
      auto_ret <= 1'b0;
      check(index, 4'h1, "uart after return");
      rdr(ADDR_INT_CTRL0, v);
      check(v, 8'h06, "flags cleared");
   endtask : t_prio
   task t_group;
      wrr(ADDR_INT_CTRL0, 8'h01);
      wrr(ADDR_GROUP0 + 4'h3, 8'h01);
      pulse(10'h100);
      wait_take(6);
      check(take, 1'b0, "group disabled");
      rdr(ADDR_INT_CTRL1, v);
      check(v, 8'h80, "group flag");
      wrr(ADDR_INT_CTRL1, 8'h88);
      wait_take(6);
      check(index, VEC_GROUP0 + 4'h3, "group vector");
      rdr(ADDR_INT_CTRL1, v);
      check(v, 8'h08, "group clear");
      pulse(10'h200);
      rdr(ADDR_GROUP0 + 4'h3, v);
      check(v, 8'h31, "sources kept");
      wrr(ADDR_GROUP0 + 4'h3, 8'h01);
      rdr(ADDR_GROUP0 + 4'h3, v);
      check(v, 8'h01, "sources cleared");
      wrr(ADDR_GROUP0 + 4'h2, 8'h02);
      for (int k = 0; k < 3; k++) begin
         pulse(18'h0_8000 << k);
         rdr(ADDR_GROUP0 + 4'h2, v);
         check(v, 8'h22, "serial flag");
         wrr(ADDR_GROUP0 + 4'h2, 8'h02);
         rdr(ADDR_GROUP0 + 4'h2, v);
         check(v, 8'h02, "serial cleared");
      end
      pulse(18'h0_0400);
      rdr(ADDR_INT_CTRL1, v);
      check(v, 8'hD8, "timer and serial group");
   endtask : t_group
   task t_tb;
      int src[5] = '{0, 1, 0, 0, 2};
      int per[5] = '{0, 0, 1, 3, 0};
      int len[5] = '{256, 1024, 512, 2048, 2048};
      int tol[5] = '{6, 6, 6, 6, 10};
      int which[5] = '{0, 0, 0, 0, 1};
      wrr(ADDR_INT_CTRL2, 8'h03);
      for (int i = 0; i < 5; i++) begin
         wrr(ADDR_TIMEBASE0_CONTROL, 8'h00);
         wrr(ADDR_TIMEBASE0_CONTROL + 4'h1, 8'h00);
         wrr(ADDR_PSC0 + 4'(which[i]), 8'(src[i]));
         wrr(ADDR_INT_CTRL0, 8'h01);
         wrr(ADDR_TIMEBASE0_CONTROL + 4'(which[i]), 8'h80 | 8'(per[i]));
         wait_take(3000);
         check(index, VEC_TB0 + 4'(which[i]), "tb vector");
         check(n > len[i] - tol[i] && n < len[i] + tol[i], 1'b1, "tb period");
      end
      wrr(ADDR_TIMEBASE0_CONTROL, 8'h00);
      wrr(ADDR_TIMEBASE0_CONTROL + 4'h1, 8'h00);
      wrr(ADDR_INT_CTRL0, 8'h01);
      wait_take(600);
      check(take, 1'b0, "tb stopped");
   endtask : t_tb
   task tally_and_finish;
      if (failures == 0 && compares > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : tally_and_finish
   initial begin
      #2_000_000;
      failures++;
      tally_and_finish();
   end
   initial begin
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      t_regs();
      t_adc();
      t_uart();
      t_prio();
      t_group();
      t_tb();
      tally_and_finish();
   end
endmodule : irq_ctrl_bench
